// ===== inc/display_list_processor_map.svh
// Field positions, opcodes, memory indices and constants of the list processor
`ifndef DISPLAY_LIST_PROCESSOR_MAP_SVH
`define DISPLAY_LIST_PROCESSOR_MAP_SVH

// Command word layout
`define OP_MSB         63
`define OP_LSB         56
`define PARAM_MSB      55
`define PARAM_LSB      32
`define SEG_ID_MSB     35
`define SEG_ID_LSB     32
`define ADDR_MSB       31
`define ADDR_LSB       0

// Segmented address layout
`define SADDR_SEG_MSB  27
`define SADDR_SEG_LSB  24
`define SADDR_OFS_MSB  23
`define SADDR_OFS_LSB  0

// Task header code word: length in 64-bit beats
`define HDR_LEN_MSB    41
`define HDR_LEN_LSB    32
`define HDR_PTR_MSB    23
`define HDR_PTR_LSB    0

// Opcodes handled by the interpreter itself
`define OP_SET_SEGMENT 8'h01
`define OP_CALL_LIST   8'h02
`define OP_BRANCH_LIST 8'h03
`define OP_END_LIST    8'h04

// Data memory words
`define HDR_CODE_IDX   9'h000
`define HDR_LIST_IDX   9'h001
`define CMD_SLOT_IDX   9'h1ff

`define STACK_DEPTH    4'ha
`define STACK_EMPTY    4'h0
`define SP_STEP        4'h1
`define ADDR_STEP      24'h000008
`define ALIGN_MSB      2
`define ALIGN_ZERO     3'h0
`define PC_BOOT        10'h000
`define PC_ENTRY       10'h000
`define LEN_ZERO       10'h000
`define LEN_STEP       10'h001
`define IDX_STEP       9'h001
`define IDX_ZERO       9'h000

`endif

// ===== inc/display_list_pkg.sv
// Types shared by the display list processor
package display_list_pkg;

  typedef enum logic [3:0] {
    st_idle   = 4'h0,
    st_header = 4'h1,
    st_code   = 4'h3,
    st_fetch  = 4'h2,
    st_decode = 4'h6,
    st_emit   = 4'h7,
    st_done   = 4'h5,
    st_fault  = 4'h4
  } state_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic [23:0] param;
    logic [23:0] addr;
  } rast_t;

  typedef struct packed {
    state_t             st;
    logic [15:0][23:0]  seg;
    logic [9:0][23:0]   stack;
    logic [3:0]         sp;
    logic [23:0]        list_ptr;
    logic [9:0]         pc;
    logic [23:0]        code_addr;
    logic [9:0]         code_left;
    logic [8:0]         code_idx;
    logic               dram_req;
    logic [23:0]        dram_addr;
    rast_t              rast;
    logic               busy;
    logic               done;
    logic               overflow_err;
    logic               align_err;
    logic               boot_err;
  } proc_state_t;

endpackage

// ===== rtl/display_list_processor.sv
// Display list interpreter: boot, segment translation and list nesting
//
// Summary of operation
// - Commands are a stream of 64-bit words
// - Sixteen segment entries, each with a base
// - Every command address translated through segment table
// - Rasterizer only ever receives physical addresses
// - Segment bases loaded by set segment command
// - Operands staged into data memory before use
// - DMA addresses must be 64-bit aligned
// - Lists nest ten deep on pointer stack
// - 4 KB instruction and 4 KB data memory
// - Boot loads task code, then jumps to task
// - First list pointer comes from task header
// - Call pushes position and follows new list
// - Branch follows new list without pushing
// - End pops to caller or finishes when empty
`timescale 1ns/1ps
`include "display_list_processor_map.svh"

module display_list_processor (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    clk_en,
  input  wire logic                    halt,
  input  wire logic                    host_wr,
  input  wire logic                    host_sel_instruction_memory,
  input  wire logic [9:0]              host_addr,
  input  wire logic [63:0]             host_wdata,
  input  wire logic                    pc_wr,
  input  wire logic [9:0]              pc_wdata,
  input  wire logic                    dram_ack,
  input  wire logic [63:0]             dram_rdata,
  input  wire logic                    rast_ready,
  output logic                         dram_req,
  output logic [23:0]                  dram_addr,
  output display_list_pkg::rast_t      rast_out,
  output logic                         busy,
  output logic                         done,
  output logic                         overflow_err,
  output logic                         align_err,
  output logic                         boot_err
);

  // Instruction memory holds 1K words, data memory 512 double words
  logic [31:0] instruction_memory [0:1023];
  logic [63:0] dmem [0:511];

  display_list_pkg::proc_state_t s;
  display_list_pkg::proc_state_t next_s;

  logic [63:0] cmd;
  logic [63:0] hdr_code;
  logic [63:0] hdr_list;
  logic [7:0]  op;
  logic [23:0] target;
  logic        code_beat;
  logic        cmd_beat;
  logic        is_set;
  logic        is_call;
  logic        is_branch;
  logic        is_end;

  // Base of the addressed segment plus the offset field
  function automatic logic [23:0] phys(input logic [15:0][23:0] tbl,
                                       input logic [31:0]       a);
    phys = tbl[a[`SADDR_SEG_MSB:`SADDR_SEG_LSB]]
           + a[`SADDR_OFS_MSB:`SADDR_OFS_LSB];
  endfunction

  assign cmd       = dmem[`CMD_SLOT_IDX];
  assign hdr_code  = dmem[`HDR_CODE_IDX];
  assign hdr_list  = dmem[`HDR_LIST_IDX];
  assign op        = cmd[`OP_MSB:`OP_LSB];
  assign target    = phys(s.seg, cmd[`ADDR_MSB:`ADDR_LSB]);
  assign code_beat = s.st == display_list_pkg::st_code && s.dram_req
                     && dram_ack && !halt;
  assign cmd_beat  = s.st == display_list_pkg::st_fetch && s.dram_req
                     && dram_ack && !halt;
  assign is_set    = s.st == display_list_pkg::st_decode
                     && op == `OP_SET_SEGMENT;
  assign is_call   = s.st == display_list_pkg::st_decode
                     && op == `OP_CALL_LIST;
  assign is_branch = s.st == display_list_pkg::st_decode
                     && op == `OP_BRANCH_LIST;
  assign is_end    = s.st == display_list_pkg::st_decode
                     && op == `OP_END_LIST;

  always_comb begin
    next_s = s;
    case (s.st)
      display_list_pkg::st_idle: begin
        next_s.busy = 1'b0;
        if (pc_wr) begin
          next_s.pc = pc_wdata;
        end
        if (!halt) begin
          next_s.overflow_err = 1'b0;
          next_s.align_err    = 1'b0;
          next_s.boot_err     = 1'b0;
          next_s.done         = 1'b0;
          // Boot only runs from the start of instruction memory
          if (s.pc != `PC_BOOT) begin
            next_s.boot_err = 1'b1;
            next_s.st       = display_list_pkg::st_fault;
          end else begin
            next_s.busy = 1'b1;
            next_s.st   = display_list_pkg::st_header;
          end
        end
      end
      display_list_pkg::st_header: begin
        next_s.code_addr = hdr_code[`HDR_PTR_MSB:`HDR_PTR_LSB];
        next_s.code_left = hdr_code[`HDR_LEN_MSB:`HDR_LEN_LSB];
        next_s.code_idx  = `IDX_ZERO;
        next_s.list_ptr  = hdr_list[`HDR_PTR_MSB:`HDR_PTR_LSB];
        next_s.sp        = `STACK_EMPTY;
        if (hdr_code[`ALIGN_MSB:0] != `ALIGN_ZERO
            || hdr_list[`ALIGN_MSB:0] != `ALIGN_ZERO) begin
          next_s.align_err = 1'b1;
          next_s.st        = display_list_pkg::st_fault;
        end else begin
          next_s.st = display_list_pkg::st_code;
        end
      end
      display_list_pkg::st_code: begin
        if (s.code_left == `LEN_ZERO) begin
          next_s.pc = `PC_ENTRY;
          next_s.st = display_list_pkg::st_fetch;
        end else if (!s.dram_req) begin
          next_s.dram_req  = 1'b1;
          next_s.dram_addr = s.code_addr;
        end else if (dram_ack) begin
          next_s.dram_req  = 1'b0;
          next_s.code_addr = s.code_addr + `ADDR_STEP;
          next_s.code_left = s.code_left - `LEN_STEP;
          next_s.code_idx  = s.code_idx + `IDX_STEP;
        end
      end
      display_list_pkg::st_fetch: begin
        if (!s.dram_req) begin
          next_s.dram_req  = 1'b1;
          next_s.dram_addr = s.list_ptr;
        end else if (dram_ack) begin
          next_s.dram_req = 1'b0;
          next_s.list_ptr = s.list_ptr + `ADDR_STEP;
          next_s.st       = display_list_pkg::st_decode;
        end
      end
      display_list_pkg::st_decode: begin
        next_s.st = display_list_pkg::st_fetch;
        if (op == `OP_SET_SEGMENT) begin
          next_s.seg[cmd[`SEG_ID_MSB:`SEG_ID_LSB]] =
            cmd[`SADDR_OFS_MSB:`SADDR_OFS_LSB];
        end else if (op == `OP_CALL_LIST || op == `OP_BRANCH_LIST) begin
          if (target[`ALIGN_MSB:0] != `ALIGN_ZERO) begin
            next_s.align_err = 1'b1;
            next_s.st        = display_list_pkg::st_fault;
          end else if (op == `OP_BRANCH_LIST) begin
            next_s.list_ptr = target;
          end else if (s.sp == `STACK_DEPTH) begin
            next_s.overflow_err = 1'b1;
            next_s.st           = display_list_pkg::st_fault;
          end else begin
            next_s.stack[s.sp] = s.list_ptr;
            next_s.sp          = s.sp + `SP_STEP;
            next_s.list_ptr    = target;
          end
        end else if (op == `OP_END_LIST) begin
          if (s.sp == `STACK_EMPTY) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
            next_s.st   = display_list_pkg::st_done;
          end else begin
            next_s.sp       = s.sp - `SP_STEP;
            next_s.list_ptr = s.stack[s.sp - `SP_STEP];
          end
        end else begin
          // Rasterizer gets the command with its address resolved
          next_s.rast.valid  = 1'b1;
          next_s.rast.opcode = op;
          next_s.rast.param  = cmd[`PARAM_MSB:`PARAM_LSB];
          next_s.rast.addr   = target;
          next_s.st          = display_list_pkg::st_emit;
        end
      end
      display_list_pkg::st_emit: begin
        if (rast_ready) begin
          next_s.rast.valid = 1'b0;
          next_s.st         = display_list_pkg::st_fetch;
        end
      end
      display_list_pkg::st_done: begin
        next_s.busy = 1'b0;
      end
      display_list_pkg::st_fault: begin
        next_s.busy = 1'b0;
      end
      default: begin
        next_s.st = display_list_pkg::st_idle;
      end
    endcase
    // Halt aborts a running task; an outstanding DMA answer is dropped
    if (halt && s.st != display_list_pkg::st_idle) begin
      next_s.st         = display_list_pkg::st_idle;
      next_s.dram_req   = 1'b0;
      next_s.rast.valid = 1'b0;
      next_s.busy       = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // Host loads memories only while halted; DMA beats land otherwise
  always_ff @(posedge clk) begin
    if (clk_en) begin
      if (halt && host_wr && host_sel_instruction_memory) begin
        instruction_memory[host_addr] <= host_wdata[31:0];
      end else if (halt && host_wr) begin
        dmem[host_addr[8:0]] <= host_wdata;
      end else if (code_beat) begin
        instruction_memory[{s.code_idx, 1'b0}] <= dram_rdata[31:0];
        instruction_memory[{s.code_idx, 1'b1}] <= dram_rdata[63:32];
      end else if (cmd_beat) begin
        dmem[`CMD_SLOT_IDX] <= dram_rdata;
      end
    end
  end

  assign dram_req     = s.dram_req;
  assign dram_addr    = s.dram_addr;
  assign rast_out     = s.rast;
  assign busy         = s.busy;
  assign done         = s.done;
  assign overflow_err = s.overflow_err;
  assign align_err    = s.align_err;
  assign boot_err     = s.boot_err;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  stack_depth_bound_a: assert property (s.sp <= `STACK_DEPTH)
    else $error("list stack deeper than ten");

  call_push_a: assert property (
    clk_en && !halt && is_call && s.sp < `STACK_DEPTH
    && target[`ALIGN_MSB:0] == `ALIGN_ZERO
    |=> s.sp == $past(s.sp) + `SP_STEP && s.list_ptr == $past(target)
        && s.stack[$past(s.sp)] == $past(s.list_ptr))
    else $error("call did not push and redirect");

  overflow_flag_a: assert property (
    clk_en && !halt && is_call && s.sp == `STACK_DEPTH
    && target[`ALIGN_MSB:0] == `ALIGN_ZERO
    |=> overflow_err && s.st == display_list_pkg::st_fault
        && s.sp == `STACK_DEPTH)
    else $error("stack overflow not flagged");

  branch_no_push_a: assert property (
    clk_en && !halt && is_branch && target[`ALIGN_MSB:0] == `ALIGN_ZERO
    |=> $stable(s.sp) && s.list_ptr == $past(target))
    else $error("branch altered the stack");

  end_pop_a: assert property (
    clk_en && !halt && is_end && s.sp != `STACK_EMPTY
    |=> s.sp == $past(s.sp) - `SP_STEP
        && s.list_ptr == $past(s.stack[s.sp - `SP_STEP]))
    else $error("end did not resume caller");

  end_finish_a: assert property (
    clk_en && !halt && is_end && s.sp == `STACK_EMPTY
    |=> done && !busy ##1 done || halt)
    else $error("end on empty stack did not finish");

  rast_physical_a: assert property (
    clk_en && !halt && s.st == display_list_pkg::st_decode && !is_set
    && !is_call && !is_branch && !is_end
    |=> rast_out.valid && rast_out.addr == $past(target))
    else $error("rasterizer address not translated");

  segment_load_a: assert property (
    clk_en && !halt && is_set
    |=> s.seg[$past(cmd[`SEG_ID_MSB:`SEG_ID_LSB])]
        == $past(cmd[`SADDR_OFS_MSB:`SADDR_OFS_LSB]))
    else $error("segment base not loaded");

  dram_aligned_a: assert property (
    $rose(dram_req) |-> dram_addr[`ALIGN_MSB:0] == `ALIGN_ZERO)
    else $error("misaligned DMA request");

  header_pointer_a: assert property (
    clk_en && !halt && s.st == display_list_pkg::st_header
    |=> s.list_ptr == $past(hdr_list[`HDR_PTR_MSB:`HDR_PTR_LSB]))
    else $error("first list pointer not from header");

  command_staged_a: assert property (
    clk_en && cmd_beat |=> s.st == display_list_pkg::st_decode
    && cmd == $past(dram_rdata))
    else $error("command not staged in data memory");

endmodule

// ===== testbench/dram_model.sv
// Shared DRAM seen by the list processor, filled by the host side
`timescale 1ns/1ps

module dram_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        dram_req,
  input  wire logic [23:0] dram_addr,
  output logic             dram_ack,
  output logic [63:0]      dram_rdata
);
  // Lists and data stay in place for the whole simulation, across tasks
  logic [63:0] mem [int];
  int          wait_n;

  // Random answer delay; idle data toggles so stale words never match
  always @(negedge clk or posedge reset) begin
    if (reset) begin
      dram_ack   <= 1'b0;
      dram_rdata <= 64'h0;
      wait_n     <= 0;
    end else if (dram_req && !dram_ack && wait_n == 0) begin
      dram_ack   <= 1'b1;
      dram_rdata <= mem.exists(int'(dram_addr)) ? mem[int'(dram_addr)]
                                                : 64'h0;
      wait_n     <= $urandom_range(3, 0);
    end else begin
      dram_ack   <= 1'b0;
      dram_rdata <= ~dram_rdata;
      if (dram_req && wait_n > 0) wait_n <= wait_n - 1;
    end
  end
endmodule

// ===== testbench/display_list_processor_bench.sv
// Self-checking bench for the display list processor
`timescale 1ns/1ps
`include "display_list_processor_map.svh"

module display_list_processor_bench;
  logic                    clk, reset, halt, host_wr, pc_wr, rast_ready;
  logic                    dram_req, dram_ack, busy, done, host_sel_instruction_memory;
  logic                    overflow_err, align_err, boot_err;
  logic [9:0]              host_addr, pc_wdata;
  logic [63:0]             host_wdata, dram_rdata;
  logic [23:0]             dram_addr;
  display_list_pkg::rast_t rast_out;
  int                      mismatches, num_checks, wp;
  logic [55:0]             exp_q [$];

  display_list_processor u_display_list_processor (
    .clk(clk), .reset(reset), .clk_en(1'b1), .halt(halt),
    .host_wr(host_wr), .host_sel_instruction_memory(host_sel_instruction_memory), .host_addr(host_addr),
    .host_wdata(host_wdata), .pc_wr(pc_wr), .pc_wdata(pc_wdata),
    .dram_ack(dram_ack), .dram_rdata(dram_rdata),
    .rast_ready(rast_ready), .dram_req(dram_req), .dram_addr(dram_addr),
    .rast_out(rast_out), .busy(busy), .done(done),
    .overflow_err(overflow_err), .align_err(align_err),
    .boot_err(boot_err));

  dram_model u_dram_model (
    .clk(clk), .reset(reset), .dram_req(dram_req), .dram_addr(dram_addr),
    .dram_ack(dram_ack), .dram_rdata(dram_rdata));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk_flag(string name, logic exp, logic got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %0b seen %0b", name, exp, got);
    end
  endtask

  task automatic chk_rast(logic [55:0] exp, logic [55:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] rast_out expected %h seen %h", exp, got);
    end
  endtask

  function automatic logic [63:0] cmd(logic [7:0] op, logic [23:0] prm,
                                      logic [3:0] sg, logic [23:0] ofs);
    return {op, prm, 4'h0, sg, ofs};
  endfunction

  task automatic put(logic [63:0] c);
    u_dram_model.mem[wp] = c;
    wp += 8;
  endtask

  task automatic fwd(logic [3:0] sg);
    put(cmd(8'($urandom_range(255, 5)), 24'($urandom), sg, 24'($urandom)));
  endtask

  // Reference walk: 0 done, 1 overflow, 2 misaligned
  function automatic int walk(int p);
    int          stk [$];
    int          t;
    logic [23:0] seg [16];
    logic [63:0] c;
    foreach (seg[i]) seg[i] = 24'h0;
    repeat (400) begin
      c = u_dram_model.mem[p];
      p += 8;
      case (c[63:56])
        `OP_SET_SEGMENT: seg[c[35:32]] = c[23:0];
        `OP_CALL_LIST, `OP_BRANCH_LIST: begin
          // Target wraps at 24 bits; alignment is judged before depth
          t = int'(24'(seg[c[27:24]] + c[23:0]));
          if (t[2:0] != 3'h0) return 2;
          if (c[63:56] == `OP_CALL_LIST) begin
            if (stk.size() == 10) return 1;
            stk.push_back(p);
          end
          p = t;
        end
        `OP_END_LIST: begin
          if (stk.size() == 0) return 0;
          p = stk.pop_back();
        end
        default:
          exp_q.push_back({c[63:56], c[55:32], seg[c[27:24]] + c[23:0]});
      endcase
    end
    return 4;
  endfunction

  // Rasterizer side stalls at random
  always @(negedge clk) rast_ready <= ($urandom_range(3, 0) != 0);

  always @(posedge clk) begin
    if (rast_out.valid === 1'b1 && rast_ready === 1'b1) begin
      chk_rast(exp_q.size() ? exp_q.pop_front() : 56'hx,
               {rast_out.opcode, rast_out.param, rast_out.addr});
    end
  end

  task automatic run_test(string name, logic [23:0] list, logic [9:0] pcv,
                          int cut);
    int st;
    int n;
    st = (pcv != 10'h0) ? 3 : walk(int'(list));
    @(negedge clk) halt = 1'b1;
    // Boot code goes in before the header, all while halted
    @(negedge clk) host_wr = 1'b1;
    host_sel_instruction_memory = 1'b1;
    host_addr = `PC_BOOT;
    host_wdata = {$urandom, $urandom};
    @(negedge clk) host_sel_instruction_memory = 1'b0;
    host_addr = {1'b0, `HDR_CODE_IDX};
    host_wdata = 64'h0000_0001_0000_0800;
    @(negedge clk) host_addr = {1'b0, `HDR_LIST_IDX};
    host_wdata = {40'h0, list};
    @(negedge clk) host_wr = 1'b0;
    pc_wr = 1'b1;
    pc_wdata = pcv;
    @(negedge clk) pc_wr = 1'b0;
    halt = 1'b0;
    n = 0;
    if (cut > 0) begin
      // Reset in mid-task; halt goes high with it so nothing reboots
      repeat (cut) @(negedge clk);
      reset = 1'b1;
      halt = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      exp_q.delete();
      st = 5;
    end
    repeat (3) @(negedge clk);
    while (st != 5 && (done | overflow_err | align_err | boot_err) !== 1'b1
           && n < 4000) begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
    chk_flag("finished", 1'b1, n < 4000);
    chk_flag("done", st == 0, done);
    chk_flag("overflow_err", st == 1, overflow_err);
    chk_flag("align_err", st == 2, align_err);
    chk_flag("boot_err", st == 3, boot_err);
    chk_flag("busy", 1'b0, busy);
    chk_flag("dram_req", 1'b0, dram_req);
    chk_flag("rast_valid", 1'b0, rast_out.valid);
    chk_flag("rast_drained", 1'b1, exp_q.size() == 0);
    exp_q.delete();
    $display("test %s ended, mismatches %0d", name, mismatches);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // A full run takes several hundred cycles
  initial begin
    #(4 * 40000);
    mismatches++;
    print_verdict();
  end

  initial begin
    reset = 1'b1;
    halt = 1'b1;
    host_wr = 1'b0;
    host_addr = 10'h0;
    host_wdata = 64'h0;
    pc_wr = 1'b0;
    pc_wdata = 10'h0;
    host_sel_instruction_memory = 1'b0;
    mismatches = 0;
    num_checks = 0;
    void'($urandom(13858));
    repeat (6) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    // Lists are complete in DRAM before any boot
    u_dram_model.mem[32'h800] = 64'h0;
    wp = 32'h1000;
    for (int i = 0; i < 16; i++)
      put(cmd(`OP_SET_SEGMENT, 24'(i), 4'h0,
              (i == 0) ? 24'h0 : 24'($urandom) & 24'hfffff8));
    for (int i = 0; i < 16; i++) fwd(4'(i));
    put(cmd(`OP_CALL_LIST, 24'h0, 4'h0, 24'h002000));
    fwd(4'h0);
    put(cmd(`OP_END_LIST, 24'h0, 4'h0, 24'h0));
    wp = 32'h2000;
    put(cmd(`OP_SET_SEGMENT, 24'h5, 4'h0, 24'h0abc40));
    fwd(4'h5);
    put(cmd(`OP_BRANCH_LIST, 24'h0, 4'h0, 24'h003000));
    fwd(4'h5);
    wp = 32'h3000;
    fwd(4'h3);
    fwd(4'h5);
    put(cmd(`OP_END_LIST, 24'h0, 4'h0, 24'h0));
    wp = 32'h4000;
    fwd(4'h0);
    put(cmd(`OP_CALL_LIST, 24'h0, 4'h0, 24'h004000));
    wp = 32'h5000;
    fwd(4'h0);
    put(cmd(`OP_BRANCH_LIST, 24'h0, 4'h0, 24'h005004));
    run_test("nested", 24'h001000, 10'h0, 0);
    run_test("reset_cut", 24'h001000, 10'h0, 100);
    run_test("overflow", 24'h004000, 10'h0, 0);
    run_test("misaligned", 24'h005000, 10'h0, 0);
    run_test("nested_again", 24'h001000, 10'h0, 0);
    run_test("bad_pc", 24'h001000, 10'h003, 0);
    print_verdict();
  end
endmodule
